//--- status_pkg.sv
// Package: widths, depths, command codes and reset values of the status block
package status_pkg;
   localparam int REG_W = 16;
   localparam int MSG_W = 16;
   localparam int Q_DEPTH = 8;
   localparam int Q_PTR_W = 3;
   localparam int LIST_DEPTH = 8;
   localparam int LIST_IDX_W = 3;
   localparam logic [REG_W-1:0] EVENT_RST = 16'h0000;
   localparam logic [REG_W-1:0] ENABLE_RST = 16'h0000;
   localparam logic [MSG_W-1:0] NO_MSG = 16'h0000;
   localparam logic [MSG_W-1:0] LIST_RST = 16'h0000;
   localparam logic [MSG_W-1:0] OVERFLOW_MSG = 16'hff9c;

   typedef enum logic [4:0] {
      CMD_NOP,
      CMD_RST,
      CMD_CLS,
      CMD_PRESET,
      CMD_OPER_EVENT_Q,
      CMD_OPER_ENABLE_W,
      CMD_OPER_ENABLE_Q,
      CMD_OPER_COND_Q,
      CMD_QUES_EVENT_Q,
      CMD_QUES_ENABLE_W,
      CMD_QUES_ENABLE_Q,
      CMD_QUES_COND_Q,
      CMD_QUEUE_NEXT_Q,
      CMD_QUEUE_ENABLE_W,
      CMD_QUEUE_ENABLE_Q,
      CMD_QUEUE_DISABLE_W,
      CMD_QUEUE_DISABLE_Q,
      CMD_QUEUE_CLEAR,
      CMD_SYS_ERROR_Q,
      CMD_SYS_CLEAR
   } status_cmd_t;
endpackage : status_pkg

//--- status_group.sv
// One condition/event/enable register group with summary flag
`timescale 1ns/10ps
module status_group
   import status_pkg::*;
(
   input wire logic sys_clk, // System clock
   input wire logic sys_rst, // Power-up reset
   input wire logic [REG_W-1:0] cond, // Live condition bits
   input wire logic clr_event, // Clear event register
   input wire logic clr_enable, // Clear enable register
   input wire logic wr_enable, // Write enable register
   input wire logic [REG_W-1:0] wr_data, // Enable value
   output logic [REG_W-1:0] event_q, // Latched event bits
   output logic [REG_W-1:0] enable_q, // Enable bits
   output logic summary // OR of event AND enable
);
   logic [REG_W-1:0] cond_prev_r;
   logic [REG_W-1:0] rise;

   assign rise = cond & ~cond_prev_r;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cond_prev_r <= '0;
      end else begin
         cond_prev_r <= cond;
      end
   end

   // Set wins over clear
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         event_q <= EVENT_RST;
      end else if (clr_event) begin
         event_q <= rise;
      end else begin
         event_q <= event_q | rise;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || clr_enable) begin
         enable_q <= ENABLE_RST;
      end else if (wr_enable) begin
         enable_q <= wr_data;
      end
   end

   assign summary = |(event_q & enable_q);
endmodule : status_group

//--- status_event_reporting.sv
// Status reporting: operation/questionable groups, message queue and filters
// Contract
// - General reset command changes no status register, queue or filter list.
// - Event registers clear at power-up and clear-status, not on preset.
// - Enable registers clear at power-up and preset, not on clear-status.
// - Message queue empties at power-up and clear-status, kept on preset.
// - Queue filter lists reset only at power-up.
// - Event query returns current latched bits of each group.
// - Each group's enable register is writable by the host.
// - Each group's enable register is readable by the host.
// - Condition query returns present unlatched condition state.
// - Preset returns enable registers to defaults, clearing them; event registers keep their bits.
// - Next-message read returns oldest queue entry, first in first out.
// - Host sets list of message codes allowed into queue.
// - Host sets list of refused codes; that list reads back.
// - Queue clear command discards every queued message.
// - System error query returns oldest message and removes it.
`timescale 1ns/10ps
module status_event_reporting
   import status_pkg::*;
(
   input wire logic sys_clk, // System clock, 25 MHz
   input wire logic sys_rst, // Power-up reset, sync high
   input wire status_cmd_t cmd, // Host command code
   input wire logic cmd_valid, // Command strobe
   input wire logic [REG_W-1:0] cmd_data, // Enable value or list entry
   input wire logic [LIST_IDX_W-1:0] cmd_index, // List entry index
   input wire logic [REG_W-1:0] oper_cond, // Operation conditions
   input wire logic [REG_W-1:0] ques_cond, // Questionable conditions
   input wire logic msg_valid, // Message posting strobe
   input wire logic [MSG_W-1:0] msg_code, // Posted message code
   output logic [REG_W-1:0] resp_data, // Query answer
   output logic resp_valid, // Answer strobe
   output logic oper_summary, // Operation summary flag
   output logic ques_summary, // Questionable summary flag
   output logic queue_empty // Queue holds nothing
);
   logic go;
   logic clr_event;
   logic clr_enable;
   logic clr_queue;
   logic pop;
   logic push;
   logic allowed;
   logic blocked;
   logic en_any;
   logic [REG_W-1:0] oper_event;
   logic [REG_W-1:0] oper_enable;
   logic [REG_W-1:0] ques_event;
   logic [REG_W-1:0] ques_enable;
   logic [MSG_W-1:0] queue_r [Q_DEPTH];
   logic [MSG_W-1:0] en_list_r [LIST_DEPTH];
   logic [MSG_W-1:0] dis_list_r [LIST_DEPTH];
   logic [LIST_DEPTH-1:0] en_hit;
   logic [LIST_DEPTH-1:0] dis_hit;
   logic [Q_PTR_W-1:0] rd_ptr_r;
   logic [Q_PTR_W-1:0] wr_ptr_r;
   logic [Q_PTR_W:0] count_r;
   logic [Q_PTR_W:0] count_nxt;
   logic [MSG_W-1:0] head;
   logic full;

   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   assign go = cmd_valid;
   // CMD_RST touches nothing here
   assign clr_event = go && (cmd == CMD_CLS);
   assign clr_enable = go && (cmd == CMD_PRESET);
   assign clr_queue = go && (cmd == CMD_CLS || cmd == CMD_QUEUE_CLEAR
                             || cmd == CMD_SYS_CLEAR);
   assign pop = go && !queue_empty && !clr_queue
                && (cmd == CMD_QUEUE_NEXT_Q || cmd == CMD_SYS_ERROR_Q);

   // ------------------------------------------------------------
   // Register groups
   // ------------------------------------------------------------
   status_group u_oper (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .cond(oper_cond),
      .clr_event(clr_event),
      .clr_enable(clr_enable),
      .wr_enable(go && cmd == CMD_OPER_ENABLE_W),
      .wr_data(cmd_data),
      .event_q(oper_event),
      .enable_q(oper_enable),
      .summary(oper_summary)
   );

   status_group u_ques (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .cond(ques_cond),
      .clr_event(clr_event),
      .clr_enable(clr_enable),
      .wr_enable(go && cmd == CMD_QUES_ENABLE_W),
      .wr_data(cmd_data),
      .event_q(ques_event),
      .enable_q(ques_enable),
      .summary(ques_summary)
   );

   // ------------------------------------------------------------
   // Message filter lists
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < LIST_DEPTH; gi++) begin : g_list
         assign en_hit[gi] = (en_list_r[gi] == msg_code);
         assign dis_hit[gi] = (dis_list_r[gi] == msg_code);

         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               en_list_r[gi] <= LIST_RST;
               dis_list_r[gi] <= LIST_RST;
            end else if (go && cmd_index == LIST_IDX_W'(gi)) begin
               if (cmd == CMD_QUEUE_ENABLE_W) begin
                  en_list_r[gi] <= cmd_data;
               end
               if (cmd == CMD_QUEUE_DISABLE_W) begin
                  dis_list_r[gi] <= cmd_data;
               end
            end
         end
      end
   endgenerate

   // Empty enable list admits every code
   always_comb begin
      en_any = 1'b1;
      for (int i = 0; i < LIST_DEPTH; i++) begin
         if (en_list_r[i] != LIST_RST) begin
            en_any = 1'b0;
         end
      end
   end

   assign allowed = en_any || (|en_hit);
   assign blocked = |dis_hit;
   assign push = msg_valid && msg_code != NO_MSG && allowed && !blocked && !clr_queue;

   // ------------------------------------------------------------
   // Message queue
   // ------------------------------------------------------------
   assign queue_empty = (count_r == '0);
   assign full = (count_r == (Q_PTR_W+1)'(Q_DEPTH));
   assign head = queue_empty ? NO_MSG : queue_r[rd_ptr_r];

   always_comb begin
      count_nxt = count_r;
      if (push && !full) begin
         count_nxt = count_nxt + 1'b1;
      end
      if (pop) begin
         count_nxt = count_nxt - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || clr_queue) begin
         rd_ptr_r <= '0;
         wr_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push && !full) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         count_r <= count_nxt;
      end
   end

   // The write that fills the queue stores an overflow mark in the last slot instead of the code; a full queue drops posts
   always_ff @(posedge sys_clk) begin
      if (push && !full) begin
         queue_r[wr_ptr_r] <= (count_r == (Q_PTR_W+1)'(Q_DEPTH-1)) ? OVERFLOW_MSG : msg_code;
      end
   end

   // ------------------------------------------------------------
   // Query answers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         resp_valid <= 1'b0;
         resp_data <= '0;
      end else begin
         resp_valid <= 1'b0;
         if (go) begin
            unique case (cmd)
               CMD_OPER_EVENT_Q: begin
                  resp_data <= oper_event;
                  resp_valid <= 1'b1;
               end
               CMD_QUES_EVENT_Q: begin
                  resp_data <= ques_event;
                  resp_valid <= 1'b1;
               end
               CMD_OPER_ENABLE_Q: begin
                  resp_data <= oper_enable;
                  resp_valid <= 1'b1;
               end
               CMD_QUES_ENABLE_Q: begin
                  resp_data <= ques_enable;
                  resp_valid <= 1'b1;
               end
               CMD_OPER_COND_Q: begin
                  resp_data <= oper_cond;
                  resp_valid <= 1'b1;
               end
               CMD_QUES_COND_Q: begin
                  resp_data <= ques_cond;
                  resp_valid <= 1'b1;
               end
               CMD_QUEUE_NEXT_Q, CMD_SYS_ERROR_Q: begin
                  resp_data <= head;
                  resp_valid <= 1'b1;
               end
               CMD_QUEUE_ENABLE_Q: begin
                  resp_data <= en_list_r[cmd_index];
                  resp_valid <= 1'b1;
               end
               CMD_QUEUE_DISABLE_Q: begin
                  resp_data <= dis_list_r[cmd_index];
                  resp_valid <= 1'b1;
               end
               default: begin
                  resp_valid <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule : status_event_reporting

//--- status_event_reporting_props.sv
// Port assertions for the status reporting block
`timescale 1ns/10ps
module status_event_reporting_props
   import status_pkg::*;
(
   input wire logic sys_clk, // Clock
   input wire logic sys_rst, // Reset
   input wire status_cmd_t cmd, // Command
   input wire logic cmd_valid, // Strobe
   input wire logic [REG_W-1:0] cmd_data, // Data
   input wire logic [LIST_IDX_W-1:0] cmd_index, // Index
   input wire logic [REG_W-1:0] oper_cond, // Oper conditions
   input wire logic [REG_W-1:0] ques_cond, // Ques conditions
   input wire logic msg_valid, // Post strobe
   input wire logic [MSG_W-1:0] msg_code, // Post code
   input wire logic [REG_W-1:0] resp_data, // Answer
   input wire logic resp_valid, // Answer strobe
   input wire logic oper_summary, // Oper summary
   input wire logic ques_summary, // Ques summary
   input wire logic queue_empty // Queue empty
);
   logic is_q;
   assign is_q = cmd inside {CMD_OPER_EVENT_Q, CMD_OPER_ENABLE_Q, CMD_OPER_COND_Q, CMD_QUES_EVENT_Q,
      CMD_QUES_ENABLE_Q, CMD_QUES_COND_Q, CMD_QUEUE_NEXT_Q, CMD_QUEUE_ENABLE_Q, CMD_QUEUE_DISABLE_Q, CMD_SYS_ERROR_Q};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_query_answered: assert property (cmd_valid && is_q |=> resp_valid) else $error("query not answered");
   a_write_silent: assert property (cmd_valid && !is_q |=> !resp_valid) else $error("answer to non-query");
   a_answer_holds: assert property (!resp_valid |-> $stable(resp_data)) else $error("answer data moved");
   a_reset_inert: assert property (cmd_valid && cmd == CMD_RST && !msg_valid |=> $stable(queue_empty))
      else $error("general reset touched queue");
   a_cls_empties: assert property (cmd_valid && cmd == CMD_CLS |=> queue_empty) else $error("queue kept on cls");
   a_clear_empties: assert property (cmd_valid && cmd inside {CMD_QUEUE_CLEAR, CMD_SYS_CLEAR} |=> queue_empty)
      else $error("queue kept on clear");
   a_preset_keeps: assert property (cmd_valid && cmd == CMD_PRESET && !queue_empty |=> !queue_empty)
      else $error("preset emptied queue");
   a_preset_quiets: assert property (cmd_valid && cmd == CMD_PRESET |=> !oper_summary && !ques_summary)
      else $error("summary after preset");
   a_pop_empty: assert property (cmd_valid && cmd == CMD_SYS_ERROR_Q && queue_empty && !msg_valid
      |=> resp_data == NO_MSG && queue_empty) else $error("pop of empty queue");
endmodule : status_event_reporting_props
bind status_event_reporting status_event_reporting_props chk (.sys_clk, .sys_rst, .cmd, .cmd_valid, .cmd_data,
   .cmd_index, .oper_cond, .ques_cond, .msg_valid, .msg_code, .resp_data, .resp_valid, .oper_summary,
   .ques_summary, .queue_empty);

//--- host_ctl_model.sv
// Host controller model issuing status commands
`timescale 1ns/10ps
module host_ctl_model
   import status_pkg::*;
(
   input wire logic sys_clk, // Clock
   input wire logic [REG_W-1:0] resp_data, // Answer
   input wire logic resp_valid, // Answer strobe
   output status_cmd_t cmd, // Command
   output logic cmd_valid, // Strobe
   output logic [REG_W-1:0] cmd_data, // Data
   output logic [LIST_IDX_W-1:0] cmd_index // Index
);
   initial begin
      cmd = CMD_NOP;
      cmd_valid = 1'b0;
      cmd_data = 16'h0000;
      cmd_index = 3'h0;
   end
   task automatic send(input status_cmd_t c, input logic [REG_W-1:0] d, input logic [LIST_IDX_W-1:0] i);
      @(posedge sys_clk);
      #1;
      cmd = c;
      cmd_data = d;
      cmd_index = i;
      cmd_valid = 1'b1;
      @(posedge sys_clk);
      #1;
      cmd_valid = 1'b0;
      cmd_data = ~d;
   endtask : send
   // Answer is registered at the taking edge
   task automatic ask(input status_cmd_t c, input logic [LIST_IDX_W-1:0] i, output logic [REG_W-1:0] rd,
      output logic rv);
      send(c, 16'h0000, i);
      rd = resp_data;
      rv = resp_valid;
   endtask : ask
endmodule : host_ctl_model

//--- status_event_reporting_tb.sv
// Self-checking testbench of the status reporting block
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin $display("BAD %s exp %h got %h", n, e, g); err_total++; end end
module status_event_reporting_tb
   import status_pkg::*;
;
   logic sys_clk, sys_rst, cmd_valid, msg_valid, resp_valid, oper_summary, ques_summary, queue_empty;
   status_cmd_t cmd;
   logic [REG_W-1:0] cmd_data, oper_cond, ques_cond, resp_data;
   logic [LIST_IDX_W-1:0] cmd_index;
   logic [MSG_W-1:0] msg_code;
   int err_total = 0;
   int samples_checked = 0;
   status_event_reporting dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd(cmd), .cmd_valid(cmd_valid),
      .cmd_data(cmd_data), .cmd_index(cmd_index), .oper_cond(oper_cond), .ques_cond(ques_cond),
      .msg_valid(msg_valid), .msg_code(msg_code), .resp_data(resp_data), .resp_valid(resp_valid),
      .oper_summary(oper_summary), .ques_summary(ques_summary), .queue_empty(queue_empty));
   host_ctl_model host (.sys_clk(sys_clk), .resp_data(resp_data), .resp_valid(resp_valid), .cmd(cmd),
      .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_index(cmd_index));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic q(input status_cmd_t c, input logic [2:0] i, input logic [15:0] e, input string n);
      logic [15:0] rd;
      logic rv;
      host.ask(c, i, rd, rv);
      `CHK(n, 1'b1, rv)
      `CHK(n, e, rd)
   endtask : q
   task automatic post(input logic [15:0] c);
      @(posedge sys_clk);
      #1 msg_valid = 1'b1;
      msg_code = c;
      @(posedge sys_clk);
      #1 msg_valid = 1'b0;
   endtask : post
   task automatic close_out();
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_power_up();
      `CHK("empty", 1'b1, queue_empty)
      q(CMD_OPER_EVENT_Q, 0, 16'h0000, "oper event");
      q(CMD_QUES_ENABLE_Q, 0, 16'h0000, "ques enable");
      q(CMD_QUEUE_DISABLE_Q, 0, 16'h0000, "dis list");
      $display("power up done");
   endtask : t_power_up
   task automatic t_regs();
      host.send(CMD_OPER_ENABLE_W, 16'h00a5, 0);
      host.send(CMD_QUES_ENABLE_W, 16'h5a00, 0);
      q(CMD_OPER_ENABLE_Q, 0, 16'h00a5, "oper enable");
      q(CMD_QUES_ENABLE_Q, 0, 16'h5a00, "ques enable");
      oper_cond = 16'h0001;
      ques_cond = 16'h0200;
      q(CMD_OPER_COND_Q, 0, 16'h0001, "oper cond");
      q(CMD_QUES_COND_Q, 0, 16'h0200, "ques cond");
      oper_cond = 16'h0000;
      ques_cond = 16'h0000;
      q(CMD_OPER_COND_Q, 0, 16'h0000, "oper cond low");
      q(CMD_OPER_EVENT_Q, 0, 16'h0001, "oper event kept");
      q(CMD_QUES_EVENT_Q, 0, 16'h0200, "ques event");
      `CHK("summaries", 2'b11, {oper_summary, ques_summary})
      host.send(CMD_RST, 16'h0000, 0);
      q(CMD_OPER_ENABLE_Q, 0, 16'h00a5, "enable after rst");
      q(CMD_OPER_EVENT_Q, 0, 16'h0001, "event after rst");
      host.send(CMD_PRESET, 16'h0000, 0);
      q(CMD_OPER_ENABLE_Q, 0, 16'h0000, "enable preset");
      q(CMD_QUES_ENABLE_Q, 0, 16'h0000, "ques enable preset");
      q(CMD_OPER_EVENT_Q, 0, 16'h0001, "event preset");
      host.send(CMD_OPER_ENABLE_W, 16'h0001, 0);
      `CHK("oper summary", 1'b1, oper_summary)
      host.send(CMD_CLS, 16'h0000, 0);
      q(CMD_OPER_EVENT_Q, 0, 16'h0000, "event cls");
      q(CMD_OPER_ENABLE_Q, 0, 16'h0001, "enable cls");
      `CHK("summary cls", 1'b0, oper_summary)
      $display("registers done");
   endtask : t_regs
   task automatic t_queue();
      post(16'h0011);
      post(16'h0022);
      post(16'h0033);
      host.send(CMD_PRESET, 16'h0000, 0);
      `CHK("kept on preset", 1'b0, queue_empty)
      q(CMD_SYS_ERROR_Q, 0, 16'h0011, "pop 1");
      q(CMD_SYS_ERROR_Q, 0, 16'h0022, "pop 2");
      q(CMD_QUEUE_NEXT_Q, 0, 16'h0033, "next");
      host.send(CMD_QUEUE_CLEAR, 16'h0000, 0);
      q(CMD_SYS_ERROR_Q, 0, 16'h0000, "after clear");
      post(16'h0044);
      host.send(CMD_CLS, 16'h0000, 0);
      `CHK("cls empty", 1'b1, queue_empty)
      post(16'h0045);
      host.send(CMD_SYS_CLEAR, 16'h0000, 0);
      `CHK("sys clear", 1'b1, queue_empty)
      $display("queue done");
   endtask : t_queue
   task automatic t_filters();
      host.send(CMD_QUEUE_DISABLE_W, 16'h0044, 3'h2);
      q(CMD_QUEUE_DISABLE_Q, 3'h2, 16'h0044, "dis list");
      post(16'h0044);
      `CHK("refused", 1'b1, queue_empty)
      host.send(CMD_QUEUE_ENABLE_W, 16'h0055, 3'h5);
      q(CMD_QUEUE_ENABLE_Q, 3'h5, 16'h0055, "en list");
      post(16'h0066);
      `CHK("not listed", 1'b1, queue_empty)
      post(16'h0055);
      `CHK("listed", 1'b0, queue_empty)
      host.send(CMD_RST, 16'h0000, 0);
      host.send(CMD_CLS, 16'h0000, 0);
      host.send(CMD_PRESET, 16'h0000, 0);
      q(CMD_QUEUE_DISABLE_Q, 3'h2, 16'h0044, "dis kept");
      q(CMD_QUEUE_ENABLE_Q, 3'h5, 16'h0055, "en kept");
      $display("filters done");
   endtask : t_filters
   task automatic t_overflow();
      host.send(CMD_QUEUE_ENABLE_W, 16'h0000, 3'h5);
      for (int k = 1; k <= 9; k++) begin
         post(16'h0060 + 16'(k));
      end
      for (int k = 1; k <= 7; k++) begin
         q(CMD_SYS_ERROR_Q, 0, 16'h0060 + 16'(k), "fifo order");
      end
      q(CMD_SYS_ERROR_Q, 0, OVERFLOW_MSG, "overflow mark");
      `CHK("drained", 1'b1, queue_empty)
      $display("overflow done");
   endtask : t_overflow
   task automatic t_power_cycle();
      host.send(CMD_QUEUE_DISABLE_W, 16'h0077, 3'h1);
      host.send(CMD_QUES_ENABLE_W, 16'h0f0f, 0);
      post(16'h0012);
      `CHK("posted", 1'b0, queue_empty)
      @(posedge sys_clk);
      #1 sys_rst = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 sys_rst = 1'b0;
      `CHK("empty after power-up", 1'b1, queue_empty)
      q(CMD_QUEUE_DISABLE_Q, 3'h1, 16'h0000, "dis list power-up");
      q(CMD_QUES_ENABLE_Q, 0, 16'h0000, "enable power-up");
      $display("power cycle done");
   endtask : t_power_cycle
   // ----------------------------------------
   // Clock, reset, sequence, watchdog
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   initial begin
      sys_rst = 1'b1;
      oper_cond = 16'h0000;
      ques_cond = 16'h0000;
      msg_valid = 1'b0;
      msg_code = 16'h0000;
      repeat (20) @(posedge sys_clk);
      #1 sys_rst = 1'b0;
      t_power_up();
      t_regs();
      t_queue();
      t_filters();
      t_overflow();
      t_power_cycle();
      close_out();
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      err_total++;
      close_out();
   end
endmodule : status_event_reporting_tb
